// file: rtl/ext_int_regs.svh
// Register map, field positions and reset values of the pin interrupt block
// Assumes a 12-bit AXI4-Lite byte address; byte address = 4 * register index
`ifndef EXT_INT_REGS_SVH
`define EXT_INT_REGS_SVH

// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define CTRL_IDX        10'h03b
`define STAT_IDX        10'h03c
`define MASK_IDX        10'h03d

// ----------------------------------------------------------------
// Control and status register fields
// ----------------------------------------------------------------
`define F_RSVD          7
`define F_PDD           6
`define F_EDG           5
`define F_PE            4
`define F_FLAG          3
`define F_ACK           2
`define F_IE            1
`define F_MODE          0

// ----------------------------------------------------------------
// Reset values and bus answers
// ----------------------------------------------------------------
`define CTRL_RESET      8'h00
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// file: rtl/ext_int_pkg.sv
// Types of the pin interrupt block
// Assumes the register header is included by the design file
package ext_int_pkg;

	// Write channel sequencing, one-hot
	typedef enum logic [1:0]
	{
		WR_IDLE = 2'h1,
		WR_RESP = 2'h2
	} wr_st_t;

	// Whole state of the block apart from the two reset release flops
	typedef struct packed
	{
		logic       pdd;
		logic       edg;
		logic       pe;
		logic       flag;
		logic       ie;
		logic       mode;
		logic [1:0] sync;
		logic       asrt_prev;
		logic       sticky;
		logic       mask;
		wr_st_t     wst;
		logic       aw_got;
		logic       w_got;
		logic [9:0] waddr;
		logic [7:0] wdata;
		logic       wstrb0;
		logic [1:0] bresp;
		logic       rvalid;
		logic [7:0] rdata;
		logic [1:0] rresp;
	} state_t;

endpackage

// file: rtl/external_pin_interrupt_detect.sv
// External interrupt pin detector with an AXI4-Lite register slave
// Assumes the pin is synchronous to ref_clk and the master keeps AXI rules
//
// Overview of operation
// - One 8-bit control and status register at index 3Bh, plus sticky status at 3Ch and mask at 3Dh; all bits zero after reset.
// - Bit 7 is reserved, reads zero and ignores writes.
// - Bit 6 at 0 keeps the internal pull device on while the pin is enabled, 1 turns it off.
// - Bit 5 picks polarity: 0 falling edge or low level, 1 rising edge or high level.
// - With the pin enabled and rising polarity chosen, the pullup is off whatever bit 6 says.
// - Bit 4 enables the pin function; with it clear the pin raises no event.
// - Bit 3 is a read-only flag set when a qualifying edge or level is seen.
// - Writing 1 to bit 2 clears the flag, writing 0 does nothing, and bit 2 reads zero.
// - In edge-and-level mode the flag cannot be cleared while the pin stays asserted.
// - Bit 1 passes the flag to the interrupt request; at 0 the flag is for polling only, but irq still follows the sticky status whenever mask is 1.
// - Bit 0 picks edge-only detection at 0 or edge-and-level detection at 1.
// - Enabling the pin sets the flag, which software clears before enabling requests.
// - While enabled, clocked logic watches the pin by the chosen mode and polarity.
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "ext_int_regs.svh"

module external_pin_interrupt_detect
	import ext_int_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	input  wire logic        irq_pin,
	output logic             pullup_en,
	output logic             irq_req,
	output logic             irq,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic   rst_meta;
	logic   rst_n;
	state_t s_q;
	state_t s_d;
	logic   asserted;
	logic   edge_det;
	logic   ctrl_wr;
	logic   ack_wr;
	logic   pe_new;
	logic   flag_set;
	logic   flag_clr;
	logic   rd_take;

	// Matches a word address against a register index
	function automatic logic hit(input logic [9:0] word, input logic [9:0] idx);
		hit = (word == idx);
	endfunction

	// Read value of the register at a word address
	function automatic logic [7:0] read_mux(input logic [9:0] word, input state_t s);
		read_mux = 8'h00;
		if (hit(word, `CTRL_IDX))
		begin
			read_mux[`F_PDD]  = s.pdd;
			read_mux[`F_EDG]  = s.edg;
			read_mux[`F_PE]   = s.pe;
			read_mux[`F_FLAG] = s.flag;
			read_mux[`F_IE]   = s.ie;
			read_mux[`F_MODE] = s.mode;
		end
		else if (hit(word, `STAT_IDX))
		begin
			read_mux[0] = s.sticky;
		end
		else if (hit(word, `MASK_IDX))
		begin
			read_mux[0] = s.mask;
		end
	endfunction

	// Known address answers OKAY, anything else SLVERR
	function automatic logic [1:0] resp_for(input logic [9:0] word);
		if (hit(word, `CTRL_IDX) || hit(word, `STAT_IDX) || hit(word, `MASK_IDX))
		begin
			resp_for = `RESP_OKAY;
		end
		else
		begin
			resp_for = `RESP_SLVERR;
		end
	endfunction

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------

	// Two flops release the asynchronous reset in step with the clock
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// ----------------------------------------------------------------
	// Pin detection terms
	// ----------------------------------------------------------------

	// polarity applied to the synchronised pin
	assign asserted = s_q.edg ? s_q.sync[1] : ~s_q.sync[1];
	// edge means a change into the asserted level
	assign edge_det = asserted & ~s_q.asrt_prev;

	// Write to the control register with its byte lane on
	assign ctrl_wr = (s_q.wst == WR_IDLE) && s_q.aw_got && s_q.w_got
		&& s_q.wstrb0 && hit(s_q.waddr, `CTRL_IDX);
	// acknowledge only on a written 1
	assign ack_wr  = ctrl_wr && s_q.wdata[`F_ACK];
	assign pe_new  = ctrl_wr ? s_q.wdata[`F_PE] : s_q.pe;

	// nothing sets the flag unless the pin is enabled after this cycle's write
	// a fresh enable sets the flag too
	// mode bit adds the level term
	assign flag_set = pe_new
		&& (!s_q.pe || edge_det || (s_q.mode && asserted));
	// an asserted pin in level mode blocks the clear
	assign flag_clr = ack_wr && !(s_q.mode && asserted && s_q.pe);

	assign rd_take = s_axi_arvalid && !s_q.rvalid;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------

	// Fills the next state from the current one and the bus
	always_comb
	begin
		s_d = s_q;

		s_d.sync      = {s_q.sync[0], irq_pin};
		s_d.asrt_prev = asserted;

		s_d.flag = flag_set || (s_q.flag && !flag_clr);

		// Sticky status follows every new set; a status read clears it
		if (rd_take && hit(s_axi_araddr[11:2], `STAT_IDX))
		begin
			s_d.sticky = 1'b0;
		end
		if (flag_set)
		begin
			s_d.sticky = 1'b1;
		end

		// Write address and data are taken in either order
		if (s_axi_awvalid && s_axi_awready)
		begin
			s_d.aw_got = 1'b1;
			s_d.waddr  = s_axi_awaddr[11:2];
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			s_d.w_got  = 1'b1;
			s_d.wdata  = s_axi_wdata[7:0];
			s_d.wstrb0 = s_axi_wstrb[0];
		end

		case (s_q.wst)
			WR_IDLE:
			begin
				if (s_q.aw_got && s_q.w_got)
				begin
					s_d.aw_got = 1'b0;
					s_d.w_got  = 1'b0;
					s_d.bresp  = resp_for(s_q.waddr);
					s_d.wst    = WR_RESP;
					if (ctrl_wr)
					begin
						// bit 7 and bit 3 are not stored from the bus
						s_d.pdd  = s_q.wdata[`F_PDD];
						s_d.edg  = s_q.wdata[`F_EDG];
						s_d.pe   = s_q.wdata[`F_PE];
						s_d.ie   = s_q.wdata[`F_IE];
						s_d.mode = s_q.wdata[`F_MODE];
					end
					if (s_q.wstrb0 && hit(s_q.waddr, `MASK_IDX))
					begin
						s_d.mask = s_q.wdata[0];
					end
				end
			end
			WR_RESP:
			begin
				if (s_axi_bready)
				begin
					s_d.wst = WR_IDLE;
				end
			end
			default:
			begin
				s_d.wst = WR_IDLE;
			end
		endcase

		// Read answer is latched when the address is taken
		if (rd_take)
		begin
			s_d.rvalid = 1'b1;
			s_d.rdata  = read_mux(s_axi_araddr[11:2], s_q);
			s_d.rresp  = resp_for(s_axi_araddr[11:2]);
		end
		else if (s_q.rvalid && s_axi_rready)
		begin
			s_d.rvalid = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_q <= '{
				pdd: 1'b0, edg: 1'b0, pe: 1'b0, flag: 1'b0,
				ie: 1'b0, mode: 1'b0, sync: 2'h0, asrt_prev: 1'b0,
				sticky: 1'b0, mask: 1'b0, wst: WR_IDLE,
				aw_got: 1'b0, w_got: 1'b0, waddr: 10'h000,
				wdata: `CTRL_RESET, wstrb0: 1'b0, bresp: `RESP_OKAY,
				rvalid: 1'b0, rdata: 8'h00, rresp: `RESP_OKAY
			};
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------

	// pullup only for falling polarity with the pull device allowed
	assign pullup_en = s_q.pe && !s_q.pdd && !s_q.edg;
	// request gated by the enable bit
	assign irq_req   = s_q.flag && s_q.ie;
	assign irq       = s_q.sticky && s_q.mask;

	// Bus handshakes
	assign s_axi_awready = (s_q.wst == WR_IDLE) && !s_q.aw_got;
	assign s_axi_wready  = (s_q.wst == WR_IDLE) && !s_q.w_got;
	assign s_axi_bvalid  = (s_q.wst == WR_RESP);
	assign s_axi_bresp   = s_q.bresp;
	assign s_axi_arready = !s_q.rvalid;
	assign s_axi_rvalid  = s_q.rvalid;
	assign s_axi_rdata   = {24'h000000, s_q.rdata};
	assign s_axi_rresp   = s_q.rresp;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------

	// An enabled pin entering its asserted level
	sequence seq_edge_in;
		s_q.pe && edge_det && pe_new;
	endsequence

	// An acknowledge with no blocking level and no new event
	sequence seq_ack_free;
		ack_wr && !(s_q.mode && asserted) && !flag_set;
	endsequence

	a_rsv_reads_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_axi_rvalid |-> !s_axi_rdata[`F_RSVD])
		else $error("reserved bit read as one");

	a_pull_default_on: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(s_q.pe && !s_q.pdd && !s_q.edg) |-> pullup_en)
		else $error("pullup off while it should be on");

	// rising polarity turns the pullup off
	a_pull_off_rise: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_q.edg |-> !pullup_en)
		else $error("pullup on with rising polarity");

	// a rising flag needs the pin enabled
	a_flag_needs_pe: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$rose(s_q.flag) |-> s_q.pe)
		else $error("flag set while pin disabled");

	// a qualifying edge sets the flag next cycle
	a_edge_sets_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
		seq_edge_in |=> s_q.flag)
		else $error("edge did not set the flag");

	// a free acknowledge clears the flag
	a_ack_clears: assert property (@(posedge ref_clk) disable iff (!rst_n)
		seq_ack_free |=> !s_q.flag)
		else $error("acknowledge did not clear the flag");

	a_ack_reads_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_axi_rvalid |-> !s_axi_rdata[`F_ACK])
		else $error("acknowledge bit read as one");

	// asserted level keeps the flag set
	a_level_holds: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(s_q.pe && s_q.mode && asserted && s_q.flag && !ctrl_wr) |=> s_q.flag)
		else $error("flag cleared while level asserted");

	a_req_gated: assert property (@(posedge ref_clk) disable iff (!rst_n)
		irq_req |-> (s_q.flag && s_q.ie))
		else $error("request without enabled flag");

	// enabling the pin sets the flag
	a_enable_sets: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$rose(s_q.pe) |-> s_q.flag)
		else $error("enable did not set the flag");

	// pin reaches detection two cycles late
	a_sync_delay: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$past(rst_n, 2) |-> (s_q.sync[1] == $past(irq_pin, 2)))
		else $error("synchroniser delay is not two");

endmodule

// file: bench/ext_pin_model.sv
// Model of the off-chip circuit that drives the interrupt request pin
// Assumes the bench sets drive_en and drive_val just after rising edges
`timescale 1ns/1ps

module ext_pin_model
(
	input  wire logic ref_clk,
	input  wire logic drive_en,
	input  wire logic drive_val,
	input  wire logic pullup_en,
	output logic      irq_pin
);
	logic wander_q = 1'b0;

	// Undriven and unpulled pin wanders every cycle
	always_ff @(posedge ref_clk)
	begin
		wander_q <= ~wander_q;
	end

	assign irq_pin = drive_en ? drive_val : (pullup_en ? 1'b1 : wander_q);
endmodule

// file: bench/external_pin_interrupt_detect_test.sv
// Self-checking bench of the pin interrupt block over AXI4-Lite
// Assumes a 50 ns ref_clk and that the pin model drives irq_pin
`timescale 1ns/1ps
`include "ext_int_regs.svh"

module external_pin_interrupt_detect_test;
	import ext_int_pkg::*;
	logic        ref_clk = 1'b0;
	logic        resetn = 1'b0;
	logic        drive_en = 1'b1;
	logic        drive_val = 1'b1;
	logic        irq_pin, pullup_en, irq_req, irq;
	logic [11:0] awaddr = 12'h000;
	logic [11:0] araddr = 12'h000;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  wstrb = 4'h0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata, rd_val;
	int          num_errors = 0;
	int          n_tests = 0;
	int          cycles = 0;

	// ----------------------------------------------------------------
	// Device, pin model, clock
	// ----------------------------------------------------------------
	external_pin_interrupt_detect i_external_pin_interrupt_detect (.ref_clk(ref_clk),
		.resetn(resetn), .irq_pin(irq_pin), .pullup_en(pullup_en), .irq_req(irq_req),
		.irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));
	ext_pin_model i_ext_pin_model (.ref_clk(ref_clk), .drive_en(drive_en),
		.drive_val(drive_val), .pullup_en(pullup_en), .irq_pin(irq_pin));

	initial
	begin
		forever #25 ref_clk = ~ref_clk;
	end

	// Cuts a hung run short
	always @(posedge ref_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			num_errors++;
			complete_run();
		end
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic complete_run();
		if (num_errors == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Handshakes are judged at the falling edge, released at the next rising edge
	task automatic axi_write(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
		logic aw, w, b;
		@(posedge ref_clk);
		awaddr <= a; awvalid <= 1'b1; wdata <= {24'h0, d}; wstrb <= 4'hf;
		wvalid <= 1'b1; bready <= 1'b1;
		b = 1'b0;
		while (!b)
		begin
			@(negedge ref_clk);
			aw = awvalid && awready;
			w = wvalid && wready;
			b = bvalid && bready;
			if (b)
				chk(32'(bresp), 32'(er));
			@(posedge ref_clk);
			if (aw) awvalid <= 1'b0;
			if (w) wvalid <= 1'b0;
			if (b) bready <= 1'b0;
		end
	endtask

	task automatic axi_read(input logic [11:0] a, input logic [1:0] er, output logic [31:0] d);
		logic ar, r;
		@(posedge ref_clk);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		r = 1'b0;
		while (!r)
		begin
			@(negedge ref_clk);
			ar = arvalid && arready;
			r = rvalid && rready;
			if (r)
			begin
				d = rdata;
				chk(32'(rresp), 32'(er));
			end
			@(posedge ref_clk);
			if (ar) arvalid <= 1'b0;
			if (r) rready <= 1'b0;
		end
	endtask

	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		axi_read(a, `RESP_OKAY, rd_val);
		chk(rd_val, {24'h0, e});
	endtask

	task automatic set_pin(input logic v);
		@(posedge ref_clk);
		drive_val <= v;
		repeat (6) @(posedge ref_clk);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		rd(12'h0ec, `CTRL_RESET);
		rd(12'h0f0, 8'h00);
		rd(12'h0f4, 8'h00);
		chk(32'({pullup_en, irq_req, irq}), 32'h0);
	endtask

	task automatic t_enable();
		axi_write(12'h0f4, 8'h01, `RESP_OKAY);
		axi_write(12'h0ec, 8'hfd, `RESP_OKAY);
		rd(12'h0ec, 8'h79);
		chk(32'({irq_req, pullup_en, irq}), 32'h1);
		axi_write(12'h0ec, 8'h04, `RESP_OKAY);
		rd(12'h0ec, 8'h08);
		axi_write(12'h0ec, 8'h04, `RESP_OKAY);
		rd(12'h0ec, 8'h00);
		rd(12'h0f0, 8'h01);
		chk(32'(irq), 32'h0);
	endtask

	task automatic t_pull();
		axi_write(12'h0ec, 8'h10, `RESP_OKAY);
		chk(32'(pullup_en), 32'h1);
		@(posedge ref_clk) drive_en <= 1'b0;
		@(negedge ref_clk) chk(32'(irq_pin), 32'h1);
		@(posedge ref_clk) drive_en <= 1'b1;
		axi_write(12'h0ec, 8'h30, `RESP_OKAY);
		chk(32'(pullup_en), 32'h0);
		axi_write(12'h0ec, 8'h50, `RESP_OKAY);
		chk(32'(pullup_en), 32'h0);
	endtask

	task automatic t_edge();
		axi_write(12'h0ec, 8'h14, `RESP_OKAY);
		rd(12'h0ec, 8'h10);
		set_pin(1'b0);
		rd(12'h0ec, 8'h18);
		chk(32'(irq_req), 32'h0);
		axi_write(12'h0ec, 8'h16, `RESP_OKAY);
		rd(12'h0ec, 8'h12);
		set_pin(1'b1);
		@(posedge ref_clk) drive_val <= 1'b0;
		repeat (2) @(posedge ref_clk);
		@(negedge ref_clk) chk(32'(irq_req), 32'h0);
		@(negedge ref_clk) chk(32'(irq_req), 32'h1);
	endtask

	task automatic t_level();
		axi_write(12'h0ec, 8'h15, `RESP_OKAY);
		rd(12'h0ec, 8'h19);
		axi_write(12'h0ec, 8'h15, `RESP_OKAY);
		rd(12'h0ec, 8'h19);
		set_pin(1'b1);
		axi_write(12'h0ec, 8'h15, `RESP_OKAY);
		rd(12'h0ec, 8'h11);
	endtask

	task automatic t_rise();
		axi_write(12'h0ec, 8'h34, `RESP_OKAY);
		axi_write(12'h0ec, 8'h34, `RESP_OKAY);
		rd(12'h0ec, 8'h30);
		set_pin(1'b0);
		rd(12'h0ec, 8'h30);
		set_pin(1'b1);
		rd(12'h0ec, 8'h38);
	endtask

	task automatic t_off();
		axi_write(12'h0ec, 8'h04, `RESP_OKAY);
		set_pin(1'b0);
		set_pin(1'b1);
		rd(12'h0ec, 8'h00);
	endtask

	task automatic t_unmapped();
		axi_write(12'h100, 8'h5a, `RESP_SLVERR);
		axi_read(12'h100, `RESP_SLVERR, rd_val);
		chk(rd_val, 32'h0);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (6) @(posedge ref_clk);
		resetn <= 1'b1;
		repeat (3) @(posedge ref_clk);
		t_reset();
		t_enable();
		t_pull();
		t_edge();
		t_level();
		t_rise();
		t_off();
		t_unmapped();
		complete_run();
	end
endmodule
